// ===== src/jtag_nvm_programming_port.sv
// Behaviour
// - Low fuse read pair ends 0110011
// - Combined read: ext, high, low fuse, lock
// - Command 0100011_00001000 selects signature reading
// - Opcode 0000011 latches signature address
// - Signature byte returned in second command
// - Calibration read entered like signature read
// - Calibration byte returned by 0110111
// - No-operation pair clears the selected mode; page load and read still run
// - Repeated leading command may be omitted
// - Read bits: zero programmed, one unprogrammed
// - Address bits above implemented top ignored
// - Byte register: shift chain plus holding
// - Update copies byte, writes within 11 TCK
// - Page load alternates low then high
// - Pre-increment before low byte except first
// - Capture loads flash byte, low first
// - Post-increment after every high byte read
// - Byte sequencer runs on test clock
// - Reset hold then exact 16-bit key unlocks
// - Zero key and reset release exit
`timescale 1ns/1ps
`default_nettype none
module jtag_nvm_programming_port
  import jtag_prog_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   tck,
  input  wire logic                   tms,
  input  wire logic                   tdi,
  output logic                        tdo,
  output logic                        tdoEnable,
  output logic                        coreHoldReset,
  output logic                        progEnabled,
  input  wire logic [BYTE_W-1:0]      fuseExt,
  input  wire logic [BYTE_W-1:0]      fuseHigh,
  input  wire logic [BYTE_W-1:0]      fuseLow,
  input  wire logic [BYTE_W-1:0]      lockBits,
  input  wire logic [SIG_COUNT*BYTE_W-1:0] signatureBytes,
  input  wire logic [BYTE_W-1:0]      calibrationByte,
  output logic [WORD_ADDR_W-1:0]      flashWordAddr,
  input  wire logic [2*BYTE_W-1:0]    flashReadData,
  output logic                        pageBufWrite,
  output logic                        pageBufHighByte,
  output logic [PAGE_IDX_W-1:0]       pageBufWordIdx,
  output logic [BYTE_W-1:0]           pageBufData
);
  tap_link_if link ();
  logic [2:0]              tckSync;
  logic [1:0]              tmsSync;
  logic [1:0]              tdiSync;
  logic                    tckRise;
  logic                    tckFall;
  logic [IR_W-1:0]         irShift;
  logic [IR_W-1:0]         irReg;
  logic [CMD_W-1:0]        cmdShift;
  logic [KEY_W-1:0]        keyShift;
  logic                    bitShift;
  logic [BYTE_W-1:0]       byteShift;
  logic [BYTE_W-1:0]       byteHold;
  logic [OPC_W-1:0]        opcodeReg;
  mode_t                   modeReg;
  logic [SIG_SEL_W-1:0]    sigAddrReg;
  logic [WORD_ADDR_W-1:0]  addrReg;
  logic                    highSelReg;
  logic                    firstByteReg;
  wseq_t                   wseqReg;
  logic                    wseqHigh;
  logic [BYTE_W-1:0]       respByte;
  logic                    tdoBit;
  logic                    atCaptureDr;
  logic                    atShiftDr;
  logic                    atUpdateDr;
  logic                    atCaptureIr;
  logic                    atShiftIr;
  logic                    atUpdateIr;
  logic                    cmdUpdate;

  // Pins from the programmer are asynchronous to clk
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tckSync <= 3'h0;
      tmsSync <= 2'h0;
      tdiSync <= 2'h0;
    end else begin
      tckSync <= {tckSync[1:0], tck};
      tmsSync <= {tmsSync[0], tms};
      tdiSync <= {tdiSync[0], tdi};
    end
  end
  // Edges are found between the second and third stage only
  assign tckRise = tckSync[1] & ~tckSync[2];
  assign tckFall = ~tckSync[1] & tckSync[2];
  assign link.tckRise = tckRise;
  assign link.tms     = tmsSync[1];
  tap_controller tapCtrl (
    .clk   (clk),
    .rst_n (rst_n),
    .link  (link)
  );
  // All TAP actions below except the TDO update on tckFall qualify on tckRise, so every sequencer is TCK-paced
  assign atCaptureDr = tckRise && (link.state == TAP_CAPTURE_DR);
  assign atShiftDr   = tckRise && (link.state == TAP_SHIFT_DR);
  assign atUpdateDr  = tckRise && (link.state == TAP_UPDATE_DR);
  assign atCaptureIr = tckRise && (link.state == TAP_CAPTURE_IR);
  assign atShiftIr   = tckRise && (link.state == TAP_SHIFT_IR);
  assign atUpdateIr  = tckRise && (link.state == TAP_UPDATE_IR);
  assign cmdUpdate   = atUpdateDr && (irReg == IR_COMMAND_ENTRY) && progEnabled;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irShift <= IR_BYPASS;
      irReg   <= IR_BYPASS;
    end else if (tckRise && link.state == TAP_RESET) begin
      irReg <= IR_BYPASS;
    end else if (atCaptureIr) begin
      irShift <= IR_CAPTURE_VALUE;
    end else if (atShiftIr) begin
      irShift <= {tdiSync[1], irShift[IR_W-1:1]};
    end else if (atUpdateIr) begin
      irReg <= irShift;
    end
  end
  // Reset hold and unlock key registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bitShift      <= 1'b0;
      keyShift      <= '0;
      coreHoldReset <= 1'b0;
      progEnabled   <= 1'b0;
    end else if (atCaptureDr) begin
      bitShift <= coreHoldReset;
      keyShift <= {{(KEY_W-1){1'b0}}, progEnabled};
    end else if (atShiftDr) begin
      bitShift <= tdiSync[1];
      keyShift <= {tdiSync[1], keyShift[KEY_W-1:1]};
    end else if (atUpdateDr && irReg == IR_CORE_HOLD_RESET) begin
      coreHoldReset <= bitShift;
    end else if (atUpdateDr && irReg == IR_UNLOCK) begin
      // Any other key, the all-zero key included, locks again
      progEnabled <= coreHoldReset && (keyShift == UNLOCK_KEY);
    end
  end
  // Response byte of the command register, chosen by the last command taken
  always_comb begin
    respByte = '0;
    case (modeReg)
      MODE_FUSE_RD: begin
        // Fuse and lock values pass unaltered: zero is programmed
        case (opcodeReg[OPC_W-1:1])
          RD_EXT_FUSE:  respByte = fuseExt;
          RD_HIGH_FUSE: respByte = fuseHigh;
          RD_LOW_BYTE:  respByte = fuseLow;
          RD_HIGH_BYTE: respByte = lockBits;
          default:      respByte = '0;
        endcase
      end
      MODE_SIG_RD: begin
        case (opcodeReg[OPC_W-1:1])
          RD_LOW_BYTE: begin
            if (sigAddrReg < SIG_SEL_W'(SIG_COUNT)) begin
              respByte = signatureBytes[sigAddrReg*BYTE_W +: BYTE_W];
            end
          end
          RD_HIGH_BYTE: respByte = calibrationByte;
          default:      respByte = '0;
        endcase
      end
      MODE_FLASH_RD: begin
        case (opcodeReg[OPC_W-1:1])
          RD_LOW_BYTE:  respByte = flashReadData[BYTE_W-1:0];
          RD_HIGH_BYTE: respByte = flashReadData[2*BYTE_W-1:BYTE_W];
          default:      respByte = '0;
        endcase
      end
      default: respByte = '0;
    endcase
  end
  // Command register: response captured into the same 15 bits that shift in
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmdShift <= '0;
    end else if (atCaptureDr && irReg == IR_COMMAND_ENTRY) begin
      cmdShift <= {opcodeReg, respByte};
    end else if (atShiftDr && irReg == IR_COMMAND_ENTRY) begin
      cmdShift <= {tdiSync[1], cmdShift[CMD_W-1:1]};
    end
  end
  // Opcode persists between commands, so a repeated leading command is harmless
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      opcodeReg  <= '0;
      modeReg    <= MODE_NONE;
      sigAddrReg <= '0;
    end else if (!progEnabled) begin
      modeReg <= MODE_NONE;
    end else if (cmdUpdate) begin
      opcodeReg <= cmdShift[CMD_W-1:ARG_W];
      if (cmdShift[CMD_W-1:ARG_W] == OPC_MODE_SELECT) begin
        case (cmdShift[ARG_W-1:0])
          ARG_SIG_RD:   modeReg <= MODE_SIG_RD;
          ARG_FUSE_RD:  modeReg <= MODE_FUSE_RD;
          ARG_FLASH_RD: modeReg <= MODE_FLASH_RD;
          ARG_FLASH_WR: modeReg <= MODE_FLASH_WR;
          default:      modeReg <= MODE_NONE;
        endcase
      end else if (cmdShift[CMD_W-1:ARG_W] == OPC_ADDR_LOW) begin
        sigAddrReg <= cmdShift[SIG_SEL_W-1:0];
      end
    end
  end
  // Word address: loaded by commands, stepped by the page streams
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addrReg <= '0;
    end else if (cmdUpdate) begin
      case (cmdShift[CMD_W-1:ARG_W])
        OPC_ADDR_LOW:  addrReg[ARG_W-1:0] <= cmdShift[ARG_W-1:0];
        // Bits past the top implemented bit are dropped
        OPC_ADDR_HIGH: addrReg[FLASH_ADDRESS_TOP_BIT:ARG_W] <=
                         cmdShift[FLASH_ADDRESS_TOP_BIT-ARG_W:0];
        default:       addrReg <= addrReg;
      endcase
    end else if (wseqReg == WSEQ_STEP && tckRise && !wseqHigh && !firstByteReg) begin
      addrReg <= addrReg + WORD_ADDR_W'(1);
    end else if (atCaptureDr && irReg == IR_PAGE_READ && highSelReg) begin
      addrReg <= addrReg + WORD_ADDR_W'(1);
    end
  end
  // Byte register: 8-bit chain plus 8-bit holding stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      byteShift <= '0;
      byteHold  <= '0;
    end else if (atCaptureDr && irReg == IR_PAGE_READ) begin
      byteShift <= highSelReg ? flashReadData[2*BYTE_W-1:BYTE_W]
                              : flashReadData[BYTE_W-1:0];
    end else if (atShiftDr) begin
      byteShift <= {tdiSync[1], byteShift[BYTE_W-1:1]};
    end else if (atUpdateDr && irReg == IR_PAGE_WRITE && progEnabled) begin
      byteHold <= byteShift;
    end
  end
  // Low/high alternation restarts whenever a new instruction is loaded
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      highSelReg   <= 1'b0;
      firstByteReg <= 1'b1;
    end else if (atUpdateIr) begin
      highSelReg   <= 1'b0;
      firstByteReg <= 1'b1;
    end else if (atUpdateDr && irReg == IR_PAGE_WRITE && progEnabled) begin
      highSelReg <= ~highSelReg;
    end else if (atCaptureDr && irReg == IR_PAGE_READ) begin
      highSelReg <= ~highSelReg;
    end else if (wseqReg == WSEQ_WRITE && tckRise) begin
      firstByteReg <= 1'b0;
    end
  end
  // Write sequencer: two TCK edges from update to buffer strobe, well inside
  // WRITE_TCK_BUDGET; a programmer shifting short bytes must idle in between
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wseqReg         <= WSEQ_IDLE;
      wseqHigh        <= 1'b0;
      pageBufWrite    <= 1'b0;
      pageBufHighByte <= 1'b0;
      pageBufWordIdx  <= '0;
      pageBufData     <= '0;
    end else begin
      pageBufWrite <= 1'b0;
      case (wseqReg)
        WSEQ_IDLE: begin
          if (atUpdateDr && irReg == IR_PAGE_WRITE && progEnabled) begin
            wseqReg  <= WSEQ_STEP;
            wseqHigh <= highSelReg;
          end
        end
        WSEQ_STEP: begin
          if (tckRise) begin
            wseqReg <= WSEQ_WRITE;
          end
        end
        WSEQ_WRITE: begin
          if (tckRise) begin
            pageBufWrite    <= 1'b1;
            pageBufHighByte <= wseqHigh;
            pageBufWordIdx  <= addrReg[PAGE_IDX_W-1:0];
            pageBufData     <= byteHold;
            wseqReg         <= WSEQ_IDLE;
          end
        end
        default: wseqReg <= WSEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flashWordAddr <= '0;
    end else begin
      flashWordAddr <= addrReg;
    end
  end

  // Output bit of the selected chain
  always_comb begin
    tdoBit = 1'b0;
    if (link.state == TAP_SHIFT_IR) begin
      tdoBit = irShift[0];
    end else begin
      case (irReg)
        IR_COMMAND_ENTRY: tdoBit = cmdShift[0];
        IR_UNLOCK:        tdoBit = keyShift[0];
        IR_PAGE_WRITE, IR_PAGE_READ: tdoBit = byteShift[0];
        default:          tdoBit = bitShift;
      endcase
    end
  end

  // Output changes on the falling TCK edge, as the programmer samples on rising
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tdo       <= 1'b0;
      tdoEnable <= 1'b0;
    end else if (tckFall) begin
      tdo       <= tdoBit;
      tdoEnable <= (link.state == TAP_SHIFT_DR) || (link.state == TAP_SHIFT_IR);
    end
  end

endmodule
`default_nettype wire

// ===== src/jtag_prog_pkg.sv
package jtag_prog_pkg;

  localparam int IR_W  = 4;
  localparam int CMD_W = 15;
  localparam int OPC_W = 7;
  localparam int ARG_W = 8;
  localparam int KEY_W = 16;
  localparam int BYTE_W = 8;
  localparam int WORD_ADDR_W = 16;
  localparam int PAGE_IDX_W = 7;
  localparam int SIG_COUNT = 3;
  localparam int SIG_SEL_W = 2;

  // Instruction codes of the test access port (values of this design)
  localparam logic [IR_W-1:0] IR_CORE_HOLD_RESET = 4'hc;
  localparam logic [IR_W-1:0] IR_UNLOCK          = 4'h4;
  localparam logic [IR_W-1:0] IR_COMMAND_ENTRY   = 4'h5;
  localparam logic [IR_W-1:0] IR_PAGE_WRITE      = 4'h6;
  localparam logic [IR_W-1:0] IR_PAGE_READ       = 4'h7;
  localparam logic [IR_W-1:0] IR_BYPASS          = 4'hf;
  localparam logic [IR_W-1:0] IR_CAPTURE_VALUE   = 4'h1;

  localparam logic [KEY_W-1:0] UNLOCK_KEY = 16'ha370;

  // Command opcodes
  localparam logic [OPC_W-1:0] OPC_MODE_SELECT = 7'h23;
  localparam logic [OPC_W-1:0] OPC_ADDR_LOW    = 7'h03;
  localparam logic [OPC_W-1:0] OPC_ADDR_HIGH   = 7'h07;
  localparam logic [OPC_W-1:0] OPC_ADDR_EXT    = 7'h0b;

  // Read opcodes, matched on the upper six bits so both halves of a pair select
  localparam logic [OPC_W-2:0] RD_EXT_FUSE  = 6'h1d;
  localparam logic [OPC_W-2:0] RD_HIGH_FUSE = 6'h1f;
  localparam logic [OPC_W-2:0] RD_LOW_BYTE  = 6'h19;
  localparam logic [OPC_W-2:0] RD_HIGH_BYTE = 6'h1b;

  // Operand of the mode-select command
  localparam logic [ARG_W-1:0] ARG_NONE      = 8'h00;
  localparam logic [ARG_W-1:0] ARG_FLASH_RD  = 8'h02;
  localparam logic [ARG_W-1:0] ARG_FUSE_RD   = 8'h04;
  localparam logic [ARG_W-1:0] ARG_SIG_RD    = 8'h08;
  localparam logic [ARG_W-1:0] ARG_FLASH_WR  = 8'h10;

  localparam int FLASH_ADDRESS_TOP_BIT = 15;

  // Longest TCK span from an update to the byte reaching the page buffer
  localparam int WRITE_TCK_BUDGET = 11;

  typedef enum logic [4:0] {
    MODE_NONE     = 5'h01,
    MODE_FLASH_RD = 5'h02,
    MODE_FUSE_RD  = 5'h04,
    MODE_SIG_RD   = 5'h08,
    MODE_FLASH_WR = 5'h10
  } mode_t;

  typedef enum logic [2:0] {
    WSEQ_IDLE  = 3'h1,
    WSEQ_STEP  = 3'h2,
    WSEQ_WRITE = 3'h4
  } wseq_t;

  typedef enum logic [15:0] {
    TAP_RESET      = 16'h0001,
    TAP_IDLE       = 16'h0002,
    TAP_SEL_DR     = 16'h0004,
    TAP_CAPTURE_DR = 16'h0008,
    TAP_SHIFT_DR   = 16'h0010,
    TAP_EXIT1_DR   = 16'h0020,
    TAP_PAUSE_DR   = 16'h0040,
    TAP_EXIT2_DR   = 16'h0080,
    TAP_UPDATE_DR  = 16'h0100,
    TAP_SEL_IR     = 16'h0200,
    TAP_CAPTURE_IR = 16'h0400,
    TAP_SHIFT_IR   = 16'h0800,
    TAP_EXIT1_IR   = 16'h1000,
    TAP_PAUSE_IR   = 16'h2000,
    TAP_EXIT2_IR   = 16'h4000,
    TAP_UPDATE_IR  = 16'h8000
  } tap_state_t;

endpackage

// ===== src/tap_controller.sv
`timescale 1ns/1ps
`default_nettype none
module tap_controller
  import jtag_prog_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  tap_link_if.ctrl  link
);

  tap_state_t stateReg;
  tap_state_t stateNext;

  assign link.state = stateReg;

  always_comb begin
    case (stateReg)
      TAP_RESET:      stateNext = link.tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE:       stateNext = link.tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR:     stateNext = link.tms ? TAP_SEL_IR : TAP_CAPTURE_DR;
      TAP_CAPTURE_DR: stateNext = link.tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR:   stateNext = link.tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR:   stateNext = link.tms ? TAP_UPDATE_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR:   stateNext = link.tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR:   stateNext = link.tms ? TAP_UPDATE_DR : TAP_SHIFT_DR;
      TAP_UPDATE_DR:  stateNext = link.tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR:     stateNext = link.tms ? TAP_RESET : TAP_CAPTURE_IR;
      TAP_CAPTURE_IR: stateNext = link.tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR:   stateNext = link.tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR:   stateNext = link.tms ? TAP_UPDATE_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR:   stateNext = link.tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR:   stateNext = link.tms ? TAP_UPDATE_IR : TAP_SHIFT_IR;
      TAP_UPDATE_IR:  stateNext = link.tms ? TAP_SEL_DR : TAP_IDLE;
      default:        stateNext = TAP_RESET;
    endcase
  end

  // Advances only on a sampled TCK rising edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stateReg <= TAP_RESET;
    end else if (link.tckRise) begin
      stateReg <= stateNext;
    end
  end

endmodule
`default_nettype wire

// ===== src/tap_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tap_link_if;
  import jtag_prog_pkg::*;
  logic       tckRise;
  logic       tms;
  tap_state_t state;
  modport ctrl (input tckRise, input tms, output state);
  modport user (output tckRise, output tms, input state);
endinterface
`default_nettype wire

// ===== test/jtag_nvm_programming_port_chk.sv
`timescale 1ns/1ps
`default_nettype none
module jtag_nvm_programming_port_chk
  import jtag_prog_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   tck,
  input  wire logic                   tdo,
  input  wire logic                   tdoEnable,
  input  wire logic                   coreHoldReset,
  input  wire logic                   progEnabled,
  input  wire logic [WORD_ADDR_W-1:0] flashWordAddr,
  input  wire logic                   pageBufWrite,
  input  wire logic                   pageBufHighByte,
  input  wire logic [PAGE_IDX_W-1:0]  pageBufWordIdx
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [PAGE_IDX_W-1:0] lowIdx_reg;
  logic                  lastHigh_reg;
  // Only tracks one page stream per reset; a new stream after a high byte is not seen
  always_ff @(posedge clk) begin
    if (!rst_n) lowIdx_reg <= '0;
    else if (pageBufWrite && !pageBufHighByte) lowIdx_reg <= pageBufWordIdx;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) lastHigh_reg <= 1'b0;
    else if (pageBufWrite) lastHigh_reg <= pageBufHighByte;
  end
  sequence lowPulse;
    pageBufWrite && !pageBufHighByte;
  endsequence
  sequence highPulse;
    pageBufWrite && pageBufHighByte;
  endsequence
  chk_pulse_spacing: assert property (pageBufWrite |=> (!pageBufWrite) [*8])
    else $error("page buffer writes too close");
  chk_write_enabled: assert property (pageBufWrite |-> progEnabled)
    else $error("page buffer write while locked");
  chk_high_same_word: assert property (
    highPulse |-> !lastHigh_reg && pageBufWordIdx == lowIdx_reg)
    else $error("high byte not paired with low byte");
  chk_low_next_word: assert property (
    lowPulse ##0 lastHigh_reg |-> pageBufWordIdx == PAGE_IDX_W'(lowIdx_reg + 1'b1))
    else $error("low byte did not step the word");
  chk_idx_tracks_addr: assert property (
    pageBufWrite |-> pageBufWordIdx == flashWordAddr[PAGE_IDX_W-1:0])
    else $error("page index differs from word address");
  chk_unlock_under_hold: assert property ($rose(progEnabled) |-> coreHoldReset)
    else $error("unlocked without core reset hold");
  chk_exit_under_hold: assert property ($fell(progEnabled) |-> coreHoldReset)
    else $error("left programming without core reset hold");
  chk_tdo_after_fall: assert property ($changed(tdo) |-> !tck)
    else $error("tdo moved while TCK high");
  chk_tdoen_after_fall: assert property ($changed(tdoEnable) |-> !tck)
    else $error("tdo enable moved while TCK high");
endmodule
bind jtag_nvm_programming_port jtag_nvm_programming_port_chk chk (
  .clk(clk), .rst_n(rst_n), .tck(tck), .tdo(tdo), .tdoEnable(tdoEnable),
  .coreHoldReset(coreHoldReset), .progEnabled(progEnabled), .flashWordAddr(flashWordAddr),
  .pageBufWrite(pageBufWrite), .pageBufHighByte(pageBufHighByte),
  .pageBufWordIdx(pageBufWordIdx));
`default_nettype wire

// ===== test/jtag_programmer.sv
`timescale 1ns/1ps
`default_nettype none
module jtag_programmer (
  input  wire logic clk,
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  initial begin
    tck <= 1'b0;
    tms <= 1'b1;
    tdi <= 1'b0;
  end
  // One TCK period: low 6 clk, high 4 clk; TCK rests low between frames
  task automatic step(input logic m, input logic d, input logic sh, output logic b);
    tms <= m;
    tdi <= sh ? d : ~tdi; // Outside shifts TDI carries nothing, so it keeps toggling
    repeat (6) @(posedge clk);
    b = tdo;
    tck <= 1'b1;
    repeat (4) @(posedge clk);
    tck <= 1'b0;
  endtask
  task automatic idle(input int n);
    logic b;
    repeat (n) step(1'b0, 1'b0, 1'b0, b);
  endtask
  // Whole scan from Run-Test/Idle back to Run-Test/Idle, LSB first
  task automatic shift(input logic ir, input logic [15:0] v, input int n,
                       output logic [15:0] o);
    logic b;
    o = '0;
    step(1'b1, 1'b0, 1'b0, b);
    if (ir) step(1'b1, 1'b0, 1'b0, b);
    step(1'b0, 1'b0, 1'b0, b);
    step(1'b0, 1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, v[i], 1'b1, b);
      o[i] = b;
    end
    step(1'b1, 1'b0, 1'b0, b);
    step(1'b0, 1'b0, 1'b0, b);
    step(1'b0, 1'b0, 1'b0, b);
    if (!ir && n < 8) idle(11);
  endtask
endmodule
`default_nettype wire

// ===== test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin n_compared++; if ((got) !== (exp)) begin failures++; \
  $display("MISMATCH t=%0t got %h expected %h", $time, (got), (exp)); end end
module testbench
  import jtag_prog_pkg::*;
;
  logic                          clk = 1'b0;
  logic                          rst_n;
  logic                          tck, tms, tdi, tdo, tdoEnable;
  logic                          coreHoldReset, progEnabled;
  logic [BYTE_W-1:0]             fuseExt, fuseHigh, fuseLow, lockBits, calibrationByte;
  logic [SIG_COUNT*BYTE_W-1:0]   signatureBytes;
  logic [WORD_ADDR_W-1:0]        flashWordAddr;
  logic [2*BYTE_W-1:0]           flashReadData;
  logic                          pageBufWrite, pageBufHighByte;
  logic [PAGE_IDX_W-1:0]         pageBufWordIdx;
  logic [BYTE_W-1:0]             pageBufData;
  logic [7:0]                    resp;
  logic [15:0]                   wrLog[$];
  int                            failures = 0;
  int                            n_compared = 0;
  int                            cycles = 0;
  jtag_programmer prog (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  jtag_nvm_programming_port DUT (
    .clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdoEnable(tdoEnable), .coreHoldReset(coreHoldReset), .progEnabled(progEnabled),
    .fuseExt(fuseExt), .fuseHigh(fuseHigh), .fuseLow(fuseLow), .lockBits(lockBits),
    .signatureBytes(signatureBytes), .calibrationByte(calibrationByte),
    .flashWordAddr(flashWordAddr), .flashReadData(flashReadData),
    .pageBufWrite(pageBufWrite), .pageBufHighByte(pageBufHighByte),
    .pageBufWordIdx(pageBufWordIdx), .pageBufData(pageBufData));
  always #4 clk = ~clk;
  // Flash model: each word holds its own address byte and a scrambled copy
  always @(posedge clk) flashReadData <= {flashWordAddr[7:0] ^ 8'h5a, flashWordAddr[7:0]};
  always @(posedge clk) if (pageBufWrite === 1'b1)
    wrLog.push_back({pageBufHighByte, pageBufWordIdx, pageBufData});
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      $display("MISMATCH t=%0t run did not finish", $time);
      wrap_up();
    end
  end
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic ir(input logic [IR_W-1:0] c);
    logic [15:0] o;
    prog.shift(1'b1, {12'h000, c}, IR_W, o);
  endtask
  // Shifts one command; resp holds the answer captured for the previous one
  task automatic cmd(input logic [14:0] c);
    logic [15:0] o;
    prog.shift(1'b0, {1'b0, c}, CMD_W, o);
    resp = o[7:0];
  endtask
  task automatic rd(input logic [14:0] c, input logic [7:0] exp);
    cmd(c);
    `CHECK(resp, exp)
  endtask
  task automatic t_enter;
    logic [15:0] o;
    ir(IR_CORE_HOLD_RESET);
    prog.shift(1'b0, 16'h0001, 1, o);
    `CHECK(coreHoldReset, 1'b1)
    ir(IR_UNLOCK);
    prog.shift(1'b0, 16'ha371, KEY_W, o);
    `CHECK(progEnabled, 1'b0)
    prog.shift(1'b0, 16'ha370, KEY_W, o);
    `CHECK(progEnabled, 1'b1)
    `CHECK(tdoEnable, 1'b0)
  endtask
  task automatic t_fuse;
    ir(IR_COMMAND_ENTRY);
    cmd(15'h2304);
    cmd(15'h3a00);
    rd(15'h3e00, fuseExt);
    rd(15'h3200, fuseHigh);
    rd(15'h3600, fuseLow);
    rd(15'h3700, lockBits);
    fuseLow <= 8'h3c;
    cmd(15'h3200);
    rd(15'h3300, 8'h3c);
    rd(15'h3300, 8'h3c);
    lockBits <= 8'hc3;
    cmd(15'h3600);
    rd(15'h3700, 8'hc3);
  endtask
  task automatic t_sig;
    ir(IR_COMMAND_ENTRY);
    cmd(15'h2308);
    for (int i = 0; i < SIG_COUNT; i++) begin
      cmd({7'h03, 8'(i)});
      cmd(15'h3200);
      rd(15'h3300, signatureBytes[8*i +: 8]);
    end
    cmd(15'h03fe);
    cmd(15'h3200);
    rd(15'h3300, signatureBytes[23:16]);
    cmd(15'h0300);
    cmd(15'h3600);
    rd(15'h3700, calibrationByte);
  endtask
  task automatic t_noop;
    ir(IR_COMMAND_ENTRY);
    cmd(15'h2300);
    cmd(15'h3300);
    cmd(15'h3200);
    rd(15'h3300, 8'h00);
    `CHECK(wrLog.size(), 0)
  endtask
  task automatic t_write;
    logic [15:0] o;
    logic [15:0] e;
    ir(IR_COMMAND_ENTRY);
    cmd(15'h2310);
    cmd(15'h0712);
    cmd(15'h0380);
    cmd(15'h0b01);
    ir(IR_PAGE_WRITE);
    for (int i = 0; i < 4; i++) prog.shift(1'b0, 16'(8'ha0 + i), BYTE_W, o);
    prog.idle(11);
    `CHECK(wrLog.size(), 4)
    for (int i = 0; i < 4; i++) begin
      e = {i[0], 7'(i >> 1), 8'(8'ha0 + i)};
      `CHECK(wrLog[i], e)
    end
    `CHECK(flashWordAddr, 16'h1281)
  endtask
  task automatic t_read;
    logic [15:0] o;
    logic [15:0] a;
    ir(IR_COMMAND_ENTRY);
    cmd(15'h2302);
    cmd(15'h0712);
    cmd(15'h0380);
    ir(IR_PAGE_READ);
    for (int i = 0; i < 4; i++) begin
      prog.shift(1'b0, 16'h0000, BYTE_W, o);
      a = 16'h1280 + 16'(i >> 1);
      `CHECK(o[7:0], i[0] ? (a[7:0] ^ 8'h5a) : a[7:0])
    end
    `CHECK(flashWordAddr, 16'h1282)
  endtask
  task automatic t_leave;
    logic [15:0] o;
    ir(IR_COMMAND_ENTRY);
    cmd(15'h2300);
    cmd(15'h3300);
    ir(IR_UNLOCK);
    prog.shift(1'b0, 16'h0000, KEY_W, o);
    `CHECK(progEnabled, 1'b0)
    ir(IR_CORE_HOLD_RESET);
    prog.shift(1'b0, 16'h0000, 1, o);
    `CHECK(coreHoldReset, 1'b0)
    ir(IR_COMMAND_ENTRY);
    cmd(15'h2304);
    cmd(15'h3200);
    rd(15'h3300, 8'h00);
  endtask
  initial begin
    rst_n <= 1'b0;
    fuseExt <= 8'hf5;
    fuseHigh <= 8'h99;
    fuseLow <= 8'h5e;
    lockBits <= 8'hfc;
    calibrationByte <= 8'h6b;
    signatureBytes <= 24'h4d_b6_29; // Arbitrary identity bytes
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    prog.idle(1);
    t_enter();
    t_fuse();
    t_sig();
    t_noop();
    t_write();
    t_read();
    t_leave();
    wrap_up();
  end
endmodule
`default_nettype wire
